// File: hw/mic_cfg.sv
// Microphone front-end configuration registers on page 1 of a paged map.
// Assumes a simple synchronous register port; a write and read share the address.
// How it works
// - Bias register bit 7 requests device software power-down; resets to 0.
// - Bias bits 1:0 choose off, 2 V, 2.5 V or analog supply rail.
// - Bit 3 clear keeps bias off when detection on and no headset.
// - Gain bit 7 resets to 1, forcing 0 dB; clear it to use code.
// - Gain code steps 0.5 dB from 0 to 59.5 dB; resets to zero.
// - Positive register selects three inputs with 10, 20 or 40 kilohm.
// - Negative register selects common-mode reference and left-minus input.
// - Common-mode bits 7:5 tie unused inputs to common mode.
// - Common-mode bit 0 reads 1 once all analog gains are applied.
// - Register 0 selects the page; these registers live on page 1.
module mic_cfg
(
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_in,
    // Register port
    input  wire logic [7:0] reg_addr_in,
    input  wire logic [7:0] reg_wdata_in,
    input  wire logic       reg_write_in,
    output logic      [7:0] reg_rdata_out,
    // Headset sense
    input  wire logic       headset_detect_en_in,
    input  wire logic       headset_present_in,
    // Analog controls
    output logic            soft_power_down_out,
    output logic      [1:0] mic_bias_supply_out,
    output logic      [6:0] mic_preamp_gain_out,
    output logic      [1:0] left_plus_mic_input_out,
    output logic      [1:0] right_plus_mic_input_out,
    output logic      [1:0] left_minus_mic_input_out,
    output logic      [1:0] common_mode_ref_out,
    output logic      [1:0] left_minus_neg_input_out,
    output logic      [2:0] tie_unused_to_cm_out
);
    logic [7:0] page;
    logic [7:0] bias_and_powerdown_ctrl;
    logic [7:0] preamp_gain_ctrl;
    logic [7:0] positive_terminal_select;
    logic [7:0] negative_terminal_select;
    logic [7:0] input_common_mode_settings;
    logic       on_page;
    logic       gain_touch;
    logic       applied;
    logic [7:0] next_rdata;

    assign on_page = (page == mic_pkg::MIC_PAGE);

    // Page register answers at address 0 on every page.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            page <= mic_pkg::PAGE_RESET;
        end
        else if (reg_write_in && reg_addr_in == mic_pkg::PAGE_SEL_ADDR)
        begin
            page <= reg_wdata_in;
        end
    end

    // Reserved bits are masked so they always read zero; writes to 51-127 are dropped.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            bias_and_powerdown_ctrl <= mic_pkg::BIAS_RESET;
        end
        else if (reg_write_in && on_page && reg_addr_in == mic_pkg::BIAS_ADDR)
        begin
            bias_and_powerdown_ctrl <= reg_wdata_in & mic_pkg::BIAS_WMASK;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            preamp_gain_ctrl <= mic_pkg::GAIN_RESET;
        end
        else if (reg_write_in && on_page && reg_addr_in == mic_pkg::GAIN_ADDR)
        begin
            preamp_gain_ctrl <= reg_wdata_in & mic_pkg::GAIN_WMASK;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            positive_terminal_select <= mic_pkg::POS_RESET;
        end
        else if (reg_write_in && on_page && reg_addr_in == mic_pkg::POS_ADDR)
        begin
            positive_terminal_select <= reg_wdata_in & mic_pkg::POS_WMASK;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            negative_terminal_select <= mic_pkg::NEG_RESET;
        end
        else if (reg_write_in && on_page && reg_addr_in == mic_pkg::NEG_ADDR)
        begin
            negative_terminal_select <= reg_wdata_in & mic_pkg::NEG_WMASK;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            input_common_mode_settings <= mic_pkg::CM_RESET;
        end
        else if (reg_write_in && on_page && reg_addr_in == mic_pkg::CM_ADDR)
        begin
            input_common_mode_settings <= reg_wdata_in & mic_pkg::CM_WMASK;
        end
    end

    // Any write to gain or input selection restarts settling, even an unchanged value.
    assign gain_touch = reg_write_in && on_page &&
                        (reg_addr_in == mic_pkg::GAIN_ADDR ||
                         reg_addr_in == mic_pkg::POS_ADDR ||
                         reg_addr_in == mic_pkg::NEG_ADDR);

    mic_settle u_settle
    (
        .clk_in     (clk_in),
        .rst_in     (rst_in),
        .restart_in (gain_touch),
        .done_out   (applied)
    );

    always_comb
    begin
        next_rdata = 8'h00;
        if (reg_addr_in == mic_pkg::PAGE_SEL_ADDR)
        begin
            next_rdata = page;
        end
        else if (!on_page)
        begin
            next_rdata = 8'h00;
        end
        else if (reg_addr_in == mic_pkg::BIAS_ADDR)
        begin
            next_rdata = bias_and_powerdown_ctrl;
        end
        else if (reg_addr_in == mic_pkg::GAIN_ADDR)
        begin
            next_rdata = preamp_gain_ctrl;
        end
        else if (reg_addr_in == mic_pkg::POS_ADDR)
        begin
            next_rdata = positive_terminal_select;
        end
        else if (reg_addr_in == mic_pkg::NEG_ADDR)
        begin
            next_rdata = negative_terminal_select;
        end
        else if (reg_addr_in == mic_pkg::CM_ADDR)
        begin
            next_rdata = input_common_mode_settings;
            next_rdata[mic_pkg::CM_APPLIED_BIT] = applied;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            reg_rdata_out <= 8'h00;
        end
        else
        begin
            reg_rdata_out <= next_rdata;
        end
    end

    // Analog controls come straight from flip-flops so the front end sees no glitches.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            soft_power_down_out <= 1'b0;
            mic_bias_supply_out <= mic_pkg::BIAS_OFF;
            mic_preamp_gain_out <= 7'h00;
        end
        else
        begin
            soft_power_down_out <= bias_and_powerdown_ctrl[mic_pkg::BIAS_PD_BIT];
            if (!bias_and_powerdown_ctrl[mic_pkg::BIAS_FORCE_BIT] &&
                headset_detect_en_in && !headset_present_in)
            begin
                mic_bias_supply_out <= mic_pkg::BIAS_OFF;
            end
            else
            begin
                mic_bias_supply_out <= bias_and_powerdown_ctrl[1:0];
            end
            if (preamp_gain_ctrl[mic_pkg::GAIN_FORCE_BIT])
            begin
                mic_preamp_gain_out <= 7'h00;
            end
            else if (preamp_gain_ctrl[6:0] > mic_pkg::GAIN_CODE_MAX)
            begin
                // Reserved codes are clamped so a bad write cannot overdrive the preamp.
                mic_preamp_gain_out <= mic_pkg::GAIN_CODE_MAX;
            end
            else
            begin
                mic_preamp_gain_out <= preamp_gain_ctrl[6:0];
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            left_plus_mic_input_out  <= 2'h0;
            right_plus_mic_input_out <= 2'h0;
            left_minus_mic_input_out <= 2'h0;
            common_mode_ref_out      <= 2'h0;
            left_minus_neg_input_out <= 2'h0;
            tie_unused_to_cm_out     <= 3'h0;
        end
        else
        begin
            left_plus_mic_input_out  <= positive_terminal_select[7:6];
            right_plus_mic_input_out <= positive_terminal_select[5:4];
            left_minus_mic_input_out <= positive_terminal_select[3:2];
            common_mode_ref_out      <= negative_terminal_select[7:6];
            left_minus_neg_input_out <= negative_terminal_select[5:4];
            tie_unused_to_cm_out     <= input_common_mode_settings[7:5];
        end
    end
endmodule : mic_cfg

// File: hw/mic_pkg.sv
// Package for the microphone front-end configuration bank.
// Assumes an 8-bit paged register port driven by a serial control bus decoder.
package mic_pkg;
    localparam logic [7:0] PAGE_SEL_ADDR   = 8'h00;
    localparam logic [7:0] MIC_PAGE        = 8'h01;
    localparam logic [7:0] PAGE_RESET      = 8'h00;
    localparam logic [7:0] BIAS_ADDR       = 8'h2e;
    localparam logic [7:0] GAIN_ADDR       = 8'h2f;
    localparam logic [7:0] POS_ADDR        = 8'h30;
    localparam logic [7:0] NEG_ADDR        = 8'h31;
    localparam logic [7:0] CM_ADDR         = 8'h32;
    localparam logic [7:0] BIAS_RESET      = 8'h00;
    localparam logic [7:0] GAIN_RESET      = 8'h80;
    localparam logic [7:0] POS_RESET       = 8'h00;
    localparam logic [7:0] NEG_RESET       = 8'h00;
    localparam logic [7:0] CM_RESET        = 8'h00;
    localparam logic [7:0] BIAS_WMASK      = 8'h8b;
    localparam logic [7:0] GAIN_WMASK      = 8'hff;
    localparam logic [7:0] POS_WMASK       = 8'hfc;
    localparam logic [7:0] NEG_WMASK       = 8'hf0;
    localparam logic [7:0] CM_WMASK        = 8'he0;
    localparam int         BIAS_PD_BIT     = 7;
    localparam int         BIAS_FORCE_BIT  = 3;
    localparam int         GAIN_FORCE_BIT  = 7;
    localparam int         CM_APPLIED_BIT  = 0;
    localparam logic [6:0] GAIN_CODE_MAX   = 7'h77;
    localparam logic [1:0] BIAS_OFF        = 2'h0;
    // Time the analog side takes to settle a new gain or input choice.
    localparam int         SETTLE_NS       = 1000;
    localparam int         CLK_NS          = 100;
    localparam int         SETTLE_CYCLES   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
endpackage : mic_pkg

// File: hw/mic_settle.sv
// Settle timer: counts a fixed delay after each restart, then reports done.
// Assumes restart is a one-cycle pulse in the register clock domain.
module mic_settle
(
    // Clock and reset
    input  wire logic clk_in,
    input  wire logic rst_in,
    // Control
    input  wire logic restart_in,
    output logic      done_out
);
    logic [7:0] count;

    always_ff @(posedge clk_in)
    begin
        if (rst_in || restart_in)
        begin
            count <= 8'(mic_pkg::SETTLE_CYCLES);
        end
        else if (count != 8'h00)
        begin
            count <= count - 8'h01;
        end
    end

    // Done stays low through reset so status starts at zero.
    always_ff @(posedge clk_in)
    begin
        if (rst_in || restart_in)
        begin
            done_out <= 1'b0;
        end
        else if (count == 8'h01)
        begin
            done_out <= 1'b1;
        end
    end
endmodule : mic_settle

// File: tb/mic_cfg_assertions.sv
// Checker for the microphone configuration bank, bound to every mic_cfg.
// Assumes one clock; the page and bias registers are shadowed here.
module mic_cfg_assertions
(
    // Watched ports
    input wire logic       clk_in,
    input wire logic       rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic       reg_write_in,
    input wire logic       headset_detect_en_in,
    input wire logic       headset_present_in,
    input wire logic       soft_power_down_out,
    input wire logic [1:0] mic_bias_supply_out,
    input wire logic [6:0] mic_preamp_gain_out,
    input wire logic [1:0] left_plus_mic_input_out,
    input wire logic [1:0] right_plus_mic_input_out,
    input wire logic [1:0] left_minus_mic_input_out,
    input wire logic [1:0] common_mode_ref_out,
    input wire logic [1:0] left_minus_neg_input_out,
    input wire logic [2:0] tie_unused_to_cm_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] page;
    logic [7:0] bias;
    logic       on_p1;
    logic       gate;
    assign on_p1 = reg_write_in && page == mic_pkg::MIC_PAGE;
    assign gate  = headset_detect_en_in && !headset_present_in && !bias[3];
    always_ff @(posedge clk_in)
        if (rst_in)
            page <= 8'h00;
        else if (reg_write_in && reg_addr_in == mic_pkg::PAGE_SEL_ADDR)
            page <= reg_wdata_in;
    always_ff @(posedge clk_in)
        if (rst_in)
            bias <= 8'h00;
        else if (on_p1 && reg_addr_in == mic_pkg::BIAS_ADDR)
            bias <= reg_wdata_in;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence wr(logic [7:0] a);
        on_p1 && reg_addr_in == a;
    endsequence

    pd_follow_a: assert property (wr(mic_pkg::BIAS_ADDR) |-> ##2
        soft_power_down_out == $past(reg_wdata_in[7], 2)) else $error("bad power-down");
    bias_gate_a: assert property (mic_bias_supply_out ==
        ($past(gate) ? 2'h0 : $past(bias[1:0]))) else $error("bad bias level");
    gain_force_a: assert property (wr(mic_pkg::GAIN_ADDR) ##0 reg_wdata_in[7]
        |-> ##2 mic_preamp_gain_out == 7'h00) else $error("gain not forced");
    gain_code_a: assert property (wr(mic_pkg::GAIN_ADDR) ##0 reg_wdata_in < 8'h78
        |-> ##2 mic_preamp_gain_out == $past(reg_wdata_in[6:0], 2)) else $error("bad gain");
    gain_clamp_a: assert property (wr(mic_pkg::GAIN_ADDR) ##0 reg_wdata_in > 8'h77
        ##0 !reg_wdata_in[7] |-> ##2 mic_preamp_gain_out == 7'h77) else $error("no clamp");
    pos_fields_a: assert property (wr(mic_pkg::POS_ADDR) |-> ##2
        {left_plus_mic_input_out, right_plus_mic_input_out, left_minus_mic_input_out}
        == $past(reg_wdata_in[7:2], 2)) else $error("bad positive select");
    neg_fields_a: assert property (wr(mic_pkg::NEG_ADDR) |-> ##2
        {common_mode_ref_out, left_minus_neg_input_out} == $past(reg_wdata_in[7:4], 2))
        else $error("bad negative select");
    cm_tie_a: assert property (wr(mic_pkg::CM_ADDR) |-> ##2
        tie_unused_to_cm_out == $past(reg_wdata_in[7:5], 2)) else $error("bad tie-off");
endmodule : mic_cfg_assertions

bind mic_cfg mic_cfg_assertions i_mic_cfg_assertions (.clk_in, .rst_in, .reg_addr_in,
    .reg_wdata_in, .reg_write_in, .headset_detect_en_in, .headset_present_in,
    .soft_power_down_out, .mic_bias_supply_out, .mic_preamp_gain_out,
    .left_plus_mic_input_out, .right_plus_mic_input_out, .left_minus_mic_input_out,
    .common_mode_ref_out, .left_minus_neg_input_out, .tie_unused_to_cm_out);

// File: tb/mic_host.sv
// Host model standing in for the serial control bus decoder.
// Assumes the bench calls its tasks; every access starts on a falling edge.
module mic_host
(
    // Register port
    input  wire logic       clk_in,
    input  wire logic [7:0] reg_rdata_in,
    output logic      [7:0] reg_addr_out,
    output logic      [7:0] reg_wdata_out,
    output logic            reg_write_out
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        reg_addr_out  = 8'h00;
        reg_wdata_out = 8'h00;
        reg_write_out = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in);
        reg_addr_out  = a;
        reg_wdata_out = d;
        reg_write_out = 1'b1;
        @(negedge clk_in);
        reg_write_out = 1'b0;
        // Stale data must not look like a valid write value.
        reg_wdata_out = ~d;
    endtask : wr

    task automatic page1();
        wr(mic_pkg::PAGE_SEL_ADDR, 8'h01);
    endtask : page1

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_in);
        reg_addr_out = a;
        @(negedge clk_in);
        d = reg_rdata_in;
    endtask : rd
endmodule : mic_host

// File: tb/tb_top.sv
// Bench for mic_cfg: the host model writes and reads the bank, outputs are compared.
// Assumes a 10 MHz clock and a synchronous active-high reset.
module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic       clk_in  = 1'b0;
    logic       rst_in  = 1'b1;
    logic       det_en  = 1'b0;
    logic       present = 1'b0;
    logic       wr_en, pd;
    logic [7:0] addr, wdata, rdata, v;
    logic [6:0] gain_o;
    logic [2:0] tie;
    logic [1:0] bias_o, lp, rp, lm, cmr, lmn;
    int         n_errors  = 0;
    int         tests_run = 0;
    int         cycles    = 0;

    always #50 clk_in = ~clk_in;

    mic_host i_mic_host (.clk_in(clk_in), .reg_rdata_in(rdata), .reg_addr_out(addr),
        .reg_wdata_out(wdata), .reg_write_out(wr_en));
    mic_cfg i_mic_cfg (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_write_in(wr_en), .reg_rdata_out(rdata),
        .headset_detect_en_in(det_en), .headset_present_in(present),
        .soft_power_down_out(pd), .mic_bias_supply_out(bias_o),
        .mic_preamp_gain_out(gain_o), .left_plus_mic_input_out(lp),
        .right_plus_mic_input_out(rp), .left_minus_mic_input_out(lm),
        .common_mode_ref_out(cmr), .left_minus_neg_input_out(lmn),
        .tie_unused_to_cm_out(tie));

    task automatic test_done();
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        i_mic_host.rd(a, v);
        chk(v, exp);
    endtask : rdchk

    // A task stuck in a wait would otherwise hang the run forever.
    always @(posedge clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            test_done();
        end
    end

    task automatic t_reset_and_paging();
        i_mic_host.page1();
        rdchk(mic_pkg::CM_ADDR, 8'h00);
        rdchk(mic_pkg::BIAS_ADDR, 8'h00);
        rdchk(mic_pkg::GAIN_ADDR, 8'h80);
        rdchk(mic_pkg::POS_ADDR, 8'h00);
        rdchk(mic_pkg::NEG_ADDR, 8'h00);
        i_mic_host.wr(mic_pkg::PAGE_SEL_ADDR, 8'h00);
        i_mic_host.wr(mic_pkg::GAIN_ADDR, 8'h05);
        i_mic_host.page1();
        rdchk(mic_pkg::GAIN_ADDR, 8'h80);
        i_mic_host.wr(8'h33, 8'h5a);
        rdchk(8'h33, 8'h00);
        rdchk(mic_pkg::CM_ADDR, 8'h01);
    endtask : t_reset_and_paging

    task automatic t_bias();
        for (int i = 0; i < 4; i++)
        begin
            i_mic_host.wr(mic_pkg::BIAS_ADDR, {i[0], 5'h00, i[1:0]});
            @(negedge clk_in);
            chk(bias_o, i[1:0]);
            chk(pd, i[0]);
        end
        det_en = 1'b1;
        repeat (2) @(negedge clk_in);
        chk(bias_o, 2'h0);
        present = 1'b1;
        repeat (2) @(negedge clk_in);
        chk(bias_o, 2'h3);
        present = 1'b0;
        i_mic_host.wr(mic_pkg::BIAS_ADDR, 8'hff);
        @(negedge clk_in);
        chk(bias_o, 2'h3);
        rdchk(mic_pkg::BIAS_ADDR, 8'h8b);
    endtask : t_bias

    task automatic t_gain();
        logic [6:0] codes [4] = '{7'h00, 7'h01, 7'h3c, 7'h77};
        for (int i = 0; i < 4; i++)
        begin
            i_mic_host.wr(mic_pkg::GAIN_ADDR, {1'b0, codes[i]});
            @(negedge clk_in);
            chk(gain_o, codes[i]);
        end
        i_mic_host.wr(mic_pkg::GAIN_ADDR, 8'hf7);
        @(negedge clk_in);
        chk(gain_o, 7'h00);
        i_mic_host.wr(mic_pkg::GAIN_ADDR, 8'h78);
        @(negedge clk_in);
        chk(gain_o, 7'h77);
    endtask : t_gain

    task automatic t_select_and_applied();
        // Let the last gain write settle first, so the later drop is a real fall.
        repeat (12) @(negedge clk_in);
        rdchk(mic_pkg::CM_ADDR, 8'h01);
        i_mic_host.wr(mic_pkg::POS_ADDR, 8'h6f);
        i_mic_host.wr(mic_pkg::NEG_ADDR, 8'h9f);
        i_mic_host.wr(mic_pkg::CM_ADDR, 8'hbf);
        @(negedge clk_in);
        chk({lp, rp, lm}, 6'h1b);
        chk({cmr, lmn}, 4'h9);
        chk(tie, 3'h5);
        rdchk(mic_pkg::POS_ADDR, 8'h6c);
        rdchk(mic_pkg::NEG_ADDR, 8'h90);
        rdchk(mic_pkg::CM_ADDR, 8'ha0);
        repeat (12) @(negedge clk_in);
        rdchk(mic_pkg::CM_ADDR, 8'ha1);
    endtask : t_select_and_applied

    initial
    begin
        repeat (10) @(negedge clk_in);
        rst_in = 1'b0;
        t_reset_and_paging();
        t_bias();
        t_gain();
        t_select_and_applied();
        test_done();
    end
endmodule : tb_top
